// ---- hdl/rffc_pkg.sv ----
// Package of constants and carrier types for the receive flow-control trigger.
// Operation
// - Any-frame set, FIFO at high mark, frame arrives: jam (half) or pause (full).
// - Full-duplex automatic pause happens only while any-frame trigger is set.
// - Half duplex any-frame: no address decode, act on valid preamble.
// - Full duplex any-frame: request pause immediately when FIFO reaches high mark.
// - Pause request stays pending until next transmit window; never interrupts a frame.
// - Any-frame trigger overrides multicast, broadcast and own-address selections.
// - Jam code picks 5..600 us at 100 Mb/s; 10 Mb/s adds 2.2 us.
// - High mark in bits 23:16 sets threshold in 64-byte units.
// - Below low mark send zero pause, only after high mark and pause sent.
// - Half duplex: each matching frame jammed for code in bits 7:4.
// - No pause frames or jamming while the transmitter is disabled.
package rffc_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [11:0] RFFC_CFG_ADDR = 12'h0ac;
    localparam logic [11:0] RFFC_STAT_ADDR = 12'h0b4;
    localparam logic [11:0] RFFC_MAC_ADDR = 12'h0b8;
    localparam logic [31:0] RFFC_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] RFFC_MAC_RESET = 32'h0000_0001;
    localparam int RFFC_HI_LSB = 16;
    localparam int RFFC_LO_LSB = 8;
    localparam int RFFC_JAM_LSB = 4;
    localparam int RFFC_MULT_BIT = 3;
    localparam int RFFC_BRD_BIT = 2;
    localparam int RFFC_OWN_BIT = 1;
    localparam int RFFC_ANY_BIT = 0;
    localparam int RFFC_TXEN_BIT = 0;
    localparam int RFFC_FDX_BIT = 1;
    localparam int RFFC_SPD_BIT = 2;
    localparam int RFFC_UNIT_SHIFT = 6;
    localparam logic [1:0] RFFC_RESP_OKAY = 2'b00;
    localparam logic [1:0] RFFC_RESP_SLVERR = 2'b10;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int RFFC_CLK_MHZ = 40;
    localparam int RFFC_SLOW_EXTRA_NS = 2200;
    localparam int RFFC_EXTRA_CYC = (RFFC_SLOW_EXTRA_NS * RFFC_CLK_MHZ + 999) / 1000;
    localparam int RFFC_CNT_W = 15;
    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [7:0] high_mark;
        logic [7:0] low_mark;
        logic [3:0] jam_code;
        logic multicast_trigger;
        logic broadcast_trigger;
        logic own_address_trigger;
        logic any_frame_trigger;
    } rffc_cfg_t;
    typedef struct packed {
        logic preamble;
        logic addr_done;
        logic is_multicast;
        logic is_broadcast;
        logic is_own;
    } rffc_rx_t;
    typedef enum logic [1:0] {
        RFFC_IDLE = 2'b00,
        RFFC_WAIT = 2'b01,
        RFFC_JAM = 2'b10
    } rffc_jam_state_t;
endpackage

// ---- hdl/rffc_jam_timer.sv ----
// Jam duration timer counted on the core clock.
`timescale 1ns/1ps
module rffc_jam_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [3:0] code,
    input wire logic speed_100,
    output logic done
);
    import rffc_pkg::*;
    logic [RFFC_CNT_W-1:0] cnt_reg;
    logic running_reg;

    // Microsecond-to-cycle mapping: 5,10,15,25,50 then 100+50*(c-5).
    function automatic logic [RFFC_CNT_W-1:0] jam_cycles(input logic [3:0] c, input logic fast);
        int us;
        us = 0;
        unique case (c)
            4'h0: us = 5;
            4'h1: us = 10;
            4'h2: us = 15;
            4'h3: us = 25;
            4'h4: us = 50;
            default: us = 100 + 50 * (int'(c) - 5);
        endcase
        jam_cycles = RFFC_CNT_W'(us * RFFC_CLK_MHZ + (fast ? 0 : RFFC_EXTRA_CYC));
    endfunction

    // Speed is latched only at start, so a mid-jam speed change cannot stretch it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            running_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                // Two less than the table count: done is registered and the jam stage needs one more edge to drop.
                cnt_reg <= jam_cycles(code, speed_100) - RFFC_CNT_W'(2);
                running_reg <= 1'b1;
            end else if (running_reg) begin
                if (cnt_reg == '0) begin
                    running_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - RFFC_CNT_W'(1);
                end
            end
        end
    end

    a_jam_min_len: assert property (@(posedge core_clk) disable iff (!nrst)
        start && code == 4'h0 && speed_100 |-> !done [*8]) else $error("Jam ended too early.");
endmodule // rffc_jam_timer

// ---- hdl/rffc_top.sv ----
// Receive FIFO automatic flow-control trigger with AXI4-Lite configuration.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module rffc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive side (same clock domain)
    input wire logic [13:0] rx_fifo_used,
    input wire rffc_pkg::rffc_rx_t rx_evt,
    // Transmit side
    input wire logic tx_busy,
    output logic pause_req,
    output logic pause_zero,
    input wire logic pause_ack,
    output logic jam_on
);
    import rffc_pkg::*;
    // ==========================================================
    // Register file
    // ==========================================================
    logic [31:0] cfg_reg;
    logic [2:0] mac_reg;
    logic aw_got_reg, w_got_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    rffc_cfg_t cfg;
    logic tx_en, full_dx, speed_100;
    assign cfg = rffc_cfg_t'(cfg_reg[23:0]);
    assign tx_en = mac_reg[RFFC_TXEN_BIT];
    assign full_dx = mac_reg[RFFC_FDX_BIT];
    assign speed_100 = mac_reg[RFFC_SPD_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                old[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge = old;
    endfunction

    logic do_write;
    assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;

    // Address and data may arrive in either order; each is held until both are in.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RFFC_RESP_OKAY;
            cfg_reg <= RFFC_CFG_RESET;
            mac_reg <= RFFC_MAC_RESET[2:0];
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            // Ready flops hold the next-state value, so they match a decode of the holding flags exactly.
            s_axi_awready <= !do_write && !aw_got_reg && !(s_axi_awvalid && s_axi_awready)
                && !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !do_write && !w_got_reg && !(s_axi_wvalid && s_axi_wready)
                && !(s_axi_bvalid && !s_axi_bready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RFFC_RESP_OKAY;
                if (aw_addr_reg == RFFC_CFG_ADDR) begin
                    cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg) & 32'h00ff_ffff;
                end else if (aw_addr_reg == RFFC_MAC_ADDR) begin
                    mac_reg <= 3'(merge({29'h0, mac_reg}, w_data_reg, w_strb_reg));
                end else if (aw_addr_reg != RFFC_STAT_ADDR) begin
                    s_axi_bresp <= RFFC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Flow-control state
    // ==========================================================
    logic above_hi, below_lo;
    logic pause_sent_reg;
    logic hi_seen_reg;
    rffc_jam_state_t jst_reg;
    logic jam_start, jam_done;
    logic match;

    assign above_hi = rx_fifo_used >= {cfg.high_mark, 6'h00};
    assign below_lo = rx_fifo_used < {cfg.low_mark, 6'h00};
    // Any-frame skips address decode entirely and fires on the preamble.
    assign match = cfg.any_frame_trigger ? rx_evt.preamble
        : rx_evt.addr_done && ((cfg.multicast_trigger && rx_evt.is_multicast)
        || (cfg.broadcast_trigger && rx_evt.is_broadcast)
        || (cfg.own_address_trigger && rx_evt.is_own));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RFFC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RFFC_RESP_OKAY;
            unique case (s_axi_araddr)
                RFFC_CFG_ADDR: s_axi_rdata <= cfg_reg;
                RFFC_MAC_ADDR: s_axi_rdata <= {29'h0, mac_reg};
                RFFC_STAT_ADDR: s_axi_rdata <= {27'h0, hi_seen_reg, pause_sent_reg, pause_req, jam_on, above_hi};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RFFC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Pause requests: full duplex, any-frame only; held until the MAC takes it between frames.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pause_req <= 1'b0;
            pause_zero <= 1'b0;
            pause_sent_reg <= 1'b0;
            hi_seen_reg <= 1'b0;
        end else if (!tx_en) begin
            pause_req <= 1'b0;
            pause_zero <= 1'b0;
        end else if (pause_req) begin
            if (pause_ack && !tx_busy) begin
                pause_req <= 1'b0;
                pause_sent_reg <= !pause_zero;
            end
        end else if (full_dx && cfg.any_frame_trigger) begin
            if (above_hi && !hi_seen_reg) begin
                hi_seen_reg <= 1'b1;
                pause_req <= 1'b1;
                pause_zero <= 1'b0;
            end else if (below_lo && hi_seen_reg) begin
                hi_seen_reg <= 1'b0;
                if (pause_sent_reg) begin
                    pause_req <= 1'b1;
                    pause_zero <= 1'b1;
                end
            end
        end
    end

    // Half-duplex jamming, one period per matching frame.
    assign jam_start = (jst_reg == RFFC_IDLE) && tx_en && !full_dx && above_hi && match;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            jst_reg <= RFFC_IDLE;
            jam_on <= 1'b0;
        end else begin
            unique case (jst_reg)
                RFFC_IDLE: begin
                    if (jam_start) begin
                        jst_reg <= RFFC_JAM;
                        jam_on <= 1'b1;
                    end
                end
                RFFC_JAM: begin
                    if (jam_done || !tx_en) begin
                        jst_reg <= RFFC_WAIT;
                        jam_on <= 1'b0;
                    end
                end
                RFFC_WAIT: begin
                    if (!rx_evt.preamble) begin
                        jst_reg <= RFFC_IDLE;
                    end
                end
                default: jst_reg <= RFFC_IDLE;
            endcase
        end
    end

    rffc_jam_timer u_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(jam_start),
        .code(cfg.jam_code),
        .speed_100(speed_100),
        .done(jam_done)
    );

    a_no_tx_off: assert property (@(posedge core_clk) disable iff (!nrst)
        !tx_en |=> !jam_on && !pause_req) else $error("Flow control active with transmitter off.");
    a_fdx_needs_any: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(pause_req) |-> $past(cfg.any_frame_trigger) && $past(full_dx)) else $error("Pause without any-frame.");
    a_pause_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        pause_req && tx_en && !(pause_ack && !tx_busy) |=> pause_req) else $error("Pause request dropped.");
    a_hi_pause: assert property (@(posedge core_clk) disable iff (!nrst)
        tx_en && full_dx && cfg.any_frame_trigger && above_hi && !hi_seen_reg && !pause_req
        |=> pause_req && !pause_zero) else $error("High mark gave no pause.");
    a_jam_half: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(jam_on) |-> !$past(full_dx)) else $error("Jam in full duplex.");
    a_any_preamble: assert property (@(posedge core_clk) disable iff (!nrst)
        jst_reg == RFFC_IDLE && tx_en && !full_dx && above_hi && cfg.any_frame_trigger && rx_evt.preamble
        |=> jam_on) else $error("Any-frame did not jam on preamble.");
    a_override: assert property (@(posedge core_clk) disable iff (!nrst)
        cfg.any_frame_trigger && !rx_evt.preamble |-> !jam_start) else $error("Selective trigger not overridden.");
    a_zero_cause: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(pause_zero) |-> $past(pause_sent_reg) && $past(below_lo)) else $error("Zero pause without cause.");
    a_threshold: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(jam_on) |-> $past(rx_fifo_used) >= {$past(cfg.high_mark), 6'h00}) else $error("Jam below high mark.");
endmodule // rffc_top

// ---- tb/rffc_station.sv ----
// Far-side model: remote station frames and the transmit-side pause handshake.
`timescale 1ns/1ps
module rffc_station (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Bench control
    input wire logic send,
    input wire logic [2:0] kind,
    input wire logic hold_tx,
    // Block side
    input wire logic pause_req,
    output rffc_pkg::rffc_rx_t rx_evt,
    output logic tx_busy,
    output logic pause_ack
);
    import rffc_pkg::*;
    logic [4:0] cnt_reg;
    // ==========================================================
    // Frame
    // ==========================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 5'h00;
        end else if (send) begin
            cnt_reg <= 5'h14;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
    end
    // The destination is known only well after the preamble, so an early reaction shows no decode was used.
    assign rx_evt = {cnt_reg != 5'h00, cnt_reg == 5'h10, kind & {3{cnt_reg == 5'h10}}};
    // ==========================================================
    // Transmitter
    // ==========================================================
    assign tx_busy = hold_tx;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pause_ack <= 1'b0;
        end else begin
            pause_ack <= pause_req & !hold_tx;
        end
    end
endmodule // rffc_station

// ---- tb/tb.sv ----
// Self-checking testbench of the receive flow-control trigger.
`timescale 1ns/1ps
module tb;
    import rffc_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [13:0] rx_fifo_used = 14'h0000;
    rffc_rx_t rx_evt;
    logic tx_busy, pause_req, pause_zero, pause_ack, jam_on;
    logic send = 1'b0, hold_tx = 1'b1;
    logic [2:0] kind = 3'h0;
    int fails = 0, checks_done = 0, cyc = 0, n;
    always #12.5 core_clk = ~core_clk;
    rffc_top dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_fifo_used, .rx_evt, .tx_busy, .pause_req, .pause_zero, .pause_ack, .jam_on);
    rffc_station far (.core_clk, .nrst, .send, .kind, .hold_tx, .pause_req, .rx_evt, .tx_busy, .pause_ack);
    task automatic results();
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ==========================================================
    // AXI4-Lite master
    // ==========================================================
    // Ready is sampled mid-cycle: inputs only move after rising edges, so it equals the value at the next edge.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, bs;
        bs = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bs) begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bs = s_axi_bvalid;
            if (bs) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (bs) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, rs;
        rs = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rs) begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            rs = s_axi_rvalid;
            if (rs) chk("rdata", s_axi_rdata, e);
            if (rs) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (rs) s_axi_rready <= 1'b0;
        end
    endtask
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic settle(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    task automatic txgo(input logic v);
        @(posedge core_clk);
        hold_tx <= v;
    endtask
    task automatic fill(input logic [13:0] u);
        @(posedge core_clk);
        rx_fifo_used <= u;
        settle(10);
    endtask
    task automatic jamlen(input logic [2:0] k, output int c);
        int w;
        w = 0;
        c = 0;
        @(posedge core_clk);
        send <= 1'b1;
        kind <= k;
        @(posedge core_clk);
        send <= 1'b0;
        while (jam_on !== 1'b1 && w < 30) begin
            @(negedge core_clk);
            w++;
        end
        while (jam_on === 1'b1 && c < 30000) begin
            @(negedge core_clk);
            c++;
        end
        settle(30);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic s_regs();
        rd(RFFC_CFG_ADDR, RFFC_CFG_RESET, RFFC_RESP_OKAY);
        rd(RFFC_MAC_ADDR, RFFC_MAC_RESET, RFFC_RESP_OKAY);
        rd(RFFC_STAT_ADDR, 32'h0000_0001, RFFC_RESP_OKAY);
        rd(12'h0c0, 32'h0, RFFC_RESP_SLVERR);
        wr(12'h0c0, 32'h1, RFFC_RESP_SLVERR);
        wr(RFFC_CFG_ADDR, 32'hffff_ffff, RFFC_RESP_OKAY);
        rd(RFFC_CFG_ADDR, 32'h00ff_ffff, RFFC_RESP_OKAY);
    endtask
    task automatic s_full();
        wr(RFFC_MAC_ADDR, 32'h3, RFFC_RESP_OKAY);
        wr(RFFC_CFG_ADDR, 32'h0002_0101, RFFC_RESP_OKAY);
        fill(14'h007f);
        chk("pause below high", pause_req, 0);
        fill(14'h0080);
        chk("pause at high", pause_req, 1);
        chk("pause time", pause_zero, 0);
        settle(20);
        chk("pause held while busy", pause_req, 1);
        txgo(1'b0);
        settle(10);
        chk("pause sent", pause_req, 0);
        txgo(1'b1);
        fill(14'h0040);
        chk("no zero pause at low", pause_req, 0);
        fill(14'h003f);
        chk("zero pause", pause_req, 1);
        chk("zero time", pause_zero, 1);
        txgo(1'b0);
        settle(10);
        chk("zero pause sent", pause_req, 0);
        txgo(1'b1);
        fill(14'h0000);
    endtask
    task automatic s_gated();
        wr(RFFC_CFG_ADDR, 32'h0002_010e, RFFC_RESP_OKAY);
        fill(14'h0080);
        chk("pause without any-frame", pause_req, 0);
        fill(14'h0000);
        wr(RFFC_MAC_ADDR, 32'h2, RFFC_RESP_OKAY);
        wr(RFFC_CFG_ADDR, 32'h0002_0101, RFFC_RESP_OKAY);
        fill(14'h0080);
        chk("pause with tx off", pause_req, 0);
        fill(14'h0000);
        wr(RFFC_MAC_ADDR, 32'h0, RFFC_RESP_OKAY);
        wr(RFFC_CFG_ADDR, 32'h0001_0001, RFFC_RESP_OKAY);
        fill(14'h0040);
        jamlen(3'h0, n);
        chk("jam with tx off", 32'(n), 0);
    endtask
    task automatic s_jam();
        wr(RFFC_MAC_ADDR, 32'h5, RFFC_RESP_OKAY);
        jamlen(3'h0, n);
        chk("jam 5us fast", 32'(n), 5 * RFFC_CLK_MHZ);
        wr(RFFC_MAC_ADDR, 32'h1, RFFC_RESP_OKAY);
        wr(RFFC_CFG_ADDR, 32'h0001_0011, RFFC_RESP_OKAY);
        jamlen(3'h0, n);
        chk("jam 10us slow", 32'(n), 10 * RFFC_CLK_MHZ + RFFC_EXTRA_CYC);
        wr(RFFC_CFG_ADDR, 32'h0001_0009, RFFC_RESP_OKAY);
        jamlen(3'h2, n);
        chk("jam any-frame over select", 32'(n), 5 * RFFC_CLK_MHZ + RFFC_EXTRA_CYC);
        wr(RFFC_CFG_ADDR, 32'h0001_0008, RFFC_RESP_OKAY);
        jamlen(3'h2, n);
        chk("jam unselected broadcast", 32'(n), 0);
        jamlen(3'h4, n);
        chk("jam multicast", 32'(n), 5 * RFFC_CLK_MHZ + RFFC_EXTRA_CYC);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        s_regs();
        s_full();
        s_gated();
        s_jam();
        results();
    end
endmodule // tb
